// ### tb.sv
`timescale 1ns/1ns
`include "wdtit_consts.vh"
module tb;
	reg                     mclk;
	reg                     rst_n;
	reg [`WDTIT_ADDR_W-1:0] reg_addr;
	reg [7:0]               reg_wdata;
	reg                     reg_wr;
	reg                     reg_rd;
	wire [7:0]              reg_rdata;
	wire                    interval_irq;
	wire                    nmi_req;
	wire                    internal_reset_req;
	wire                    reset_out_pin_n;
	wire [7:0]              nmi_count;
	wire [7:0]              rst_len;
	integer                 n_fail;
	integer                 check_count;
	integer                 i;
	integer                 dv [0:5] = '{2, 64, 128, 512, 2048, 8192};
	integer                 nt [0:5] = '{4, 4, 4, 4, 4, 1};
	reg [7:0]               a;
	reg [7:0]               v;
	wdtit_top i_dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.interval_irq, .nmi_req, .internal_reset_req, .reset_out_pin_n);
	wdtit_sys_model i_sys (.mclk, .rst_n, .nmi_req, .internal_reset_req, .nmi_count, .rst_len);
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task wrap_up;
	begin
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk(input [7:0] seen, input [7:0] exp, input string what);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task wr(input [2:0] ad, input [7:0] d);
	begin
		@(posedge mclk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	end
	endtask
	// read data stand one cycle only, so sample at the next falling edge
	task rd(input [2:0] ad, output [7:0] q);
	begin
		@(posedge mclk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		q = reg_rdata;
	end
	endtask
	task rc(input [2:0] ad, input [7:0] exp, input string what);
	begin
		rd(ad, v);
		chk(v, exp, what);
	end
	endtask
	task gw(input [2:0] ad, input [7:0] d);
	begin
		wr(`WDTIT_OFS_KEY, `WDTIT_UNLOCK_KEY);
		wr(ad, d);
	end
	endtask
	task wait_irq;
	begin
		for (i = 0; i < 100 && interval_irq !== 1'b1; i = i + 1)
			@(negedge mclk);
	end
	endtask
	initial
	begin
		#(40 * 40000);
		n_fail = n_fail + 1;
		wrap_up;
	end
	initial
	begin
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rc(`WDTIT_OFS_CTRL, 8'h00, "ctrl reset");
		rc(`WDTIT_OFS_COUNT, 8'h00, "count reset");
		wr(`WDTIT_OFS_CTRL, 8'h20);
		rc(`WDTIT_OFS_CTRL, 8'h00, "unguarded ctrl");
		rc(`WDTIT_OFS_EVT_STATUS, 8'h02, "guard event");
		rc(`WDTIT_OFS_EVT_STATUS, 8'h00, "status read clear");
		wr(`WDTIT_OFS_KEY, `WDTIT_UNLOCK_KEY);
		rc(`WDTIT_OFS_KEY, 8'h01, "key armed");
		wr(`WDTIT_OFS_EVT_STATUS, 8'h00);
		rc(`WDTIT_OFS_KEY, 8'h00, "key disarmed");
		rc(3'h7, 8'h00, "unmapped read");
		gw(`WDTIT_OFS_COUNT, 8'h42);
		rc(`WDTIT_OFS_COUNT, 8'h00, "count while off");
		gw(`WDTIT_OFS_CTRL, 8'h80);
		rc(`WDTIT_OFS_CTRL, 8'h00, "flag set by write");
		wr(`WDTIT_OFS_EVT_MASK, 8'h01);
		rc(`WDTIT_OFS_EVT_MASK, 8'h01, "mask");
		// spacing is a multiple of the divider, so the step is exact whatever the phase;
		// the two slowest codes would take too long, one tick at 8192 is the limit here
		for (i = 0; i < 6; i = i + 1)
		begin
			gw(`WDTIT_OFS_CTRL, {5'b00100, i[2:0]});
			rd(`WDTIT_OFS_COUNT, a);
			repeat (nt[i] * dv[i] - 2) @(posedge mclk);
			rd(`WDTIT_OFS_COUNT, v);
			chk(v - a, nt[i][7:0], "count step");
		end
		// every control write keeps the reserved bit at zero
		gw(`WDTIT_OFS_CTRL, 8'h20);
		gw(`WDTIT_OFS_COUNT, 8'hF0);
		wait_irq;
		chk(interval_irq, 8'h01, "interval irq");
		rc(`WDTIT_OFS_CTRL, 8'hA0, "wrap flag");
		gw(`WDTIT_OFS_CTRL, 8'hA0);
		rc(`WDTIT_OFS_CTRL, 8'hA0, "flag kept");
		gw(`WDTIT_OFS_CTRL, 8'h20);
		rc(`WDTIT_OFS_CTRL, 8'h20, "flag cleared");
		rc(`WDTIT_OFS_EVT_STATUS, 8'h01, "wrap event");
		gw(`WDTIT_OFS_COUNT, 8'hF0);
		wait_irq;
		gw(`WDTIT_OFS_CTRL, 8'h00);
		rc(`WDTIT_OFS_CTRL, 8'h00, "flag by enable");
		rc(`WDTIT_OFS_COUNT, 8'h00, "count zeroed");
		rd(`WDTIT_OFS_EVT_STATUS, v);
		wr(`WDTIT_OFS_EVT_MASK, 8'h00);
		gw(`WDTIT_OFS_CTRL, 8'h60);
		gw(`WDTIT_OFS_COUNT, 8'hF0);
		for (i = 0; i < 100 && nmi_req !== 1'b1; i = i + 1)
			@(negedge mclk);
		rc(`WDTIT_OFS_CTRL, 8'hE0, "watchdog flag");
		// interrupt masked off, so the flag is polled and must be seen twice
		rc(`WDTIT_OFS_CTRL, 8'hE0, "flag polled twice");
		chk(nmi_count, 8'h01, "nmi pulses");
		gw(`WDTIT_OFS_CTRL, 8'h68);
		gw(`WDTIT_OFS_COUNT, 8'hF0);
		for (i = 0; i < 100 && reset_out_pin_n !== 1'b0; i = i + 1)
			@(negedge mclk);
		chk(reset_out_pin_n, 8'h00, "reset pin low");
		for (i = 0; i < 40 && reset_out_pin_n !== 1'b1; i = i + 1)
			@(negedge mclk);
		repeat (2) @(negedge mclk);
		chk(rst_len, 8'h10, "reset length");
		rc(`WDTIT_OFS_CTRL, 8'h68, "flag after reset");
		gw(`WDTIT_OFS_CTRL, 8'h00);
		wrap_up;
	end
endmodule

// ### wdtit_checker.sv
`timescale 1ns/1ns
`include "wdtit_consts.vh"
module wdtit_checker
(
	input wire                     mclk,
	input wire                     rst_n,
	input wire [`WDTIT_ADDR_W-1:0] reg_addr,
	input wire [7:0]               reg_wdata,
	input wire                     reg_wr,
	input wire                     reg_rd,
	input wire [7:0]               reg_rdata,
	input wire                     interval_irq,
	input wire                     nmi_req,
	input wire                     internal_reset_req,
	input wire                     reset_out_pin_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_pin_mirrors_req: assert property (reset_out_pin_n == !internal_reset_req)
		else $error("reset pin differs from reset request");
	a_reset_pulse_len: assert property ($rose(internal_reset_req) |->
		internal_reset_req[*8] ##1 internal_reset_req[*8] ##1 !internal_reset_req)
		else $error("reset request not sixteen cycles long");
	a_nmi_one_cycle: assert property (nmi_req |=> !nmi_req)
		else $error("nmi request longer than one cycle");
	a_nmi_no_pin: assert property (nmi_req |-> reset_out_pin_n)
		else $error("reset pin driven on nmi action");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");
	a_rsvd_reads_zero: assert property (reg_rd && reg_addr == `WDTIT_OFS_CTRL |=>
		!reg_rdata[`WDTIT_BIT_RSVD])
		else $error("reserved control bit read as one");
	a_status_read_clr: assert property (reg_rd && reg_addr == `WDTIT_OFS_EVT_STATUS
		|-> ##[1:2] !interval_irq)
		else $error("interrupt stays after status read");
	a_mask_off_clr: assert property (reg_wr && reg_addr == `WDTIT_OFS_EVT_MASK
		&& reg_wdata == 8'h00 |-> ##[1:2] !interval_irq)
		else $error("interrupt stays with mask cleared");
	c_irq: cover property ($rose(interval_irq));
	c_rst: cover property ($rose(internal_reset_req));
	c_nmi: cover property (nmi_req);
endmodule

bind wdtit_top wdtit_checker i_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .interval_irq, .nmi_req, .internal_reset_req, .reset_out_pin_n);

// ### wdtit_consts.vh
`ifndef WDTIT_CONSTS_VH
`define WDTIT_CONSTS_VH

// register offsets on the local port
`define WDTIT_ADDR_W            3
`define WDTIT_OFS_COUNT         3'h0
`define WDTIT_OFS_CTRL          3'h1
`define WDTIT_OFS_KEY           3'h2
`define WDTIT_OFS_EVT_STATUS    3'h3
`define WDTIT_OFS_EVT_MASK      3'h4

// control/status field positions
`define WDTIT_BIT_WRAP          7
`define WDTIT_BIT_MODE          6
`define WDTIT_BIT_ENABLE        5
`define WDTIT_BIT_RSVD          4
`define WDTIT_BIT_ACTION        3
`define WDTIT_CKS_HI            2
`define WDTIT_CKS_LO            0

// event status / mask field positions
`define WDTIT_EVT_W             2
`define WDTIT_EVT_INTERVAL      0
`define WDTIT_EVT_GUARD         1

// reset values and count maximum
`define WDTIT_RST_COUNT         8'h00
`define WDTIT_RST_CTRL          8'h00
`define WDTIT_RST_EVT           2'h0
`define WDTIT_COUNT_MAX         8'hFF

// unlock key (value arbitrary)
`define WDTIT_UNLOCK_KEY        8'h5A

// prescaler taps: log2 of divide ratio for select codes 000..111
`define WDTIT_PRE_W             17
`define WDTIT_TAP0              1
`define WDTIT_TAP1              6
`define WDTIT_TAP2              7
`define WDTIT_TAP3              9
`define WDTIT_TAP4              11
`define WDTIT_TAP5              13
`define WDTIT_TAP6              15
`define WDTIT_TAP7              17

// reset-out low time in clock cycles
`define WDTIT_RSTOUT_CYCLES     8'h10

`endif

// ### wdtit_prescaler.v
`timescale 1ns/1ns
`include "wdtit_consts.vh"

module wdtit_prescaler
(
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       run,
	input  wire [2:0] divide_select,
	output reg        tick
);

	reg  [`WDTIT_PRE_W-1:0] pre_q;
	wire [`WDTIT_PRE_W:0]   ones;

	// ones[j] is high when the low j bits of the prescaler are all set
	assign ones[0] = 1'b1;
	genvar j;
	generate
		for (j = 0; j < `WDTIT_PRE_W; j = j + 1)
		begin : g_ones
			assign ones[j+1] = ones[j] & pre_q[j];
		end
	endgenerate

	// cleared while stopped so the first tick after enable is a full period
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			pre_q <= {`WDTIT_PRE_W{1'b0}};
		else if (!run)
			pre_q <= {`WDTIT_PRE_W{1'b0}};
		else
			pre_q <= pre_q + {{(`WDTIT_PRE_W-1){1'b0}}, 1'b1};
	end

	always @*
	begin
		case (divide_select)
			3'h0:    tick = run & ones[`WDTIT_TAP0];
			3'h1:    tick = run & ones[`WDTIT_TAP1];
			3'h2:    tick = run & ones[`WDTIT_TAP2];
			3'h3:    tick = run & ones[`WDTIT_TAP3];
			3'h4:    tick = run & ones[`WDTIT_TAP4];
			3'h5:    tick = run & ones[`WDTIT_TAP5];
			3'h6:    tick = run & ones[`WDTIT_TAP6];
			3'h7:    tick = run & ones[`WDTIT_TAP7];
			default: tick = 1'b0;
		endcase
	end

endmodule

// ### wdtit_sys_model.sv
`timescale 1ns/1ns
// chip reset and interrupt side: records requests only, so the run can go on
module wdtit_sys_model
(
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       nmi_req,
	input  wire       internal_reset_req,
	output reg  [7:0] nmi_count,
	output reg  [7:0] rst_len
);
	reg [7:0] run_q;
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nmi_count <= 8'h00;
			rst_len <= 8'h00;
			run_q <= 8'h00;
		end
		else
		begin
			nmi_count <= nmi_count + {7'h00, nmi_req};
			run_q <= internal_reset_req ? run_q + 8'h01 : 8'h00;
			if (!internal_reset_req && run_q != 8'h00)
				rst_len <= run_q;
		end
	end
endmodule

// ### wdtit_top.v
`timescale 1ns/1ns
`include "wdtit_consts.vh"

module wdtit_top
(
	input  wire                     mclk,
	input  wire                     rst_n,
	input  wire [`WDTIT_ADDR_W-1:0] reg_addr,
	input  wire [7:0]               reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output reg  [7:0]               reg_rdata,
	output reg                      interval_irq,
	output reg                      nmi_req,
	output reg                      internal_reset_req,
	output reg                      reset_out_pin_n
);

	localparam ST_IDLE  = 2'b01;
	localparam ST_PULSE = 2'b10;

	reg  [7:0]              count_q;
	reg  [7:0]              count_d;
	reg                     wrap_flag_q;
	reg                     wrap_flag_d;
	reg                     wrap_seen_q;
	reg                     wrap_seen_d;
	reg                     mode_q;
	reg                     enable_q;
	reg                     action_q;
	reg  [2:0]              cks_q;
	reg                     unlock_q;
	reg                     unlock_d;
	reg  [`WDTIT_EVT_W-1:0] evt_status_q;
	reg  [`WDTIT_EVT_W-1:0] evt_status_d;
	reg  [`WDTIT_EVT_W-1:0] evt_mask_q;
	reg  [1:0]              state_q;
	reg  [1:0]              state_d;
	reg  [7:0]              pulse_cnt_q;
	reg  [7:0]              pulse_cnt_d;

	wire                    tick;
	wire                    hit_count;
	wire                    hit_ctrl;
	wire                    hit_key;
	wire                    hit_status;
	wire                    hit_mask;
	wire                    guarded_hit;
	wire                    wr_ok;
	wire                    wr_bad;
	wire                    wr_count;
	wire                    wr_ctrl;
	wire                    wrap;
	wire                    wrap_interval;
	wire                    wrap_nmi;
	wire                    wrap_reset;
	wire                    pulse_done;
	wire [7:0]              ctrl_view;

	assign hit_count  = (reg_addr == `WDTIT_OFS_COUNT);
	assign hit_ctrl   = (reg_addr == `WDTIT_OFS_CTRL);
	assign hit_key    = (reg_addr == `WDTIT_OFS_KEY);
	assign hit_status = (reg_addr == `WDTIT_OFS_EVT_STATUS);
	assign hit_mask   = (reg_addr == `WDTIT_OFS_EVT_MASK);

	// stray stores from a crashed program must not feed the dog
	assign guarded_hit = hit_count | hit_ctrl;
	assign wr_ok       = reg_wr & guarded_hit & unlock_q;
	assign wr_bad      = reg_wr & guarded_hit & ~unlock_q;
	assign wr_count    = wr_ok & hit_count;
	assign wr_ctrl     = wr_ok & hit_ctrl;

	wdtit_prescaler u_prescaler
	(
		.mclk          (mclk),
		.rst_n         (rst_n),
		.run           (enable_q),
		.divide_select (cks_q),
		.tick          (tick)
	);

	// a software write to the count wins over a simultaneous tick
	assign wrap = tick & enable_q & ~wr_count & (count_q == `WDTIT_COUNT_MAX);

	assign wrap_interval = wrap & ~mode_q;
	assign wrap_nmi      = wrap & mode_q & ~action_q;
	assign wrap_reset    = wrap & mode_q & action_q;

	assign pulse_done = (state_q == ST_PULSE) && (pulse_cnt_q == 8'h01);

	// reserved bit reads zero whatever software wrote
	assign ctrl_view = {wrap_flag_q, mode_q, enable_q, 1'b0, action_q, cks_q};

	// counter
	always @*
	begin
		count_d = count_q;
		if (!enable_q)
			count_d = `WDTIT_RST_COUNT;
		else if (wr_count)
			count_d = reg_wdata;
		else if (tick)
			count_d = count_q + 8'h01;
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= `WDTIT_RST_COUNT;
		else
			count_q <= count_d;
	end

	// control fields
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q   <= 1'b0;
			enable_q <= 1'b0;
			action_q <= 1'b0;
			cks_q    <= 3'h0;
		end
		else if (wr_ctrl)
		begin
			mode_q   <= reg_wdata[`WDTIT_BIT_MODE];
			enable_q <= reg_wdata[`WDTIT_BIT_ENABLE];
			action_q <= reg_wdata[`WDTIT_BIT_ACTION];
			cks_q    <= reg_wdata[`WDTIT_CKS_HI:`WDTIT_CKS_LO];
		end
	end

	// wrap flag: cleared by reading one then writing zero, by enable low,
	// or by the end of the internal reset; a new wrap wins over any clear
	always @*
	begin
		wrap_flag_d = wrap_flag_q;
		wrap_seen_d = wrap_seen_q;
		if (reg_rd && hit_ctrl && wrap_flag_q)
			wrap_seen_d = 1'b1;
		if (wr_ctrl)
		begin
			if (!reg_wdata[`WDTIT_BIT_WRAP] && wrap_seen_q)
			begin
				wrap_flag_d = 1'b0;
				wrap_seen_d = 1'b0;
			end
			if (!reg_wdata[`WDTIT_BIT_ENABLE])
			begin
				wrap_flag_d = 1'b0;
				wrap_seen_d = 1'b0;
			end
		end
		if (pulse_done)
		begin
			wrap_flag_d = 1'b0;
			wrap_seen_d = 1'b0;
		end
		if (wrap)
		begin
			wrap_flag_d = 1'b1;
			wrap_seen_d = 1'b0;
		end
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrap_flag_q <= 1'b0;
			wrap_seen_q <= 1'b0;
		end
		else
		begin
			wrap_flag_q <= wrap_flag_d;
			wrap_seen_q <= wrap_seen_d;
		end
	end

	// unlock: a key write arms exactly one guarded write; any other
	// write disarms it, so the key cannot be parked ahead of time
	always @*
	begin
		unlock_d = unlock_q;
		if (reg_wr)
		begin
			if (hit_key)
				unlock_d = (reg_wdata == `WDTIT_UNLOCK_KEY);
			else
				unlock_d = 1'b0;
		end
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			unlock_q <= 1'b0;
		else
			unlock_q <= unlock_d;
	end

	// reset-out sequencer
	always @*
	begin
		state_d     = state_q;
		pulse_cnt_d = pulse_cnt_q;
		case (state_q)
			ST_IDLE:
			begin
				if (wrap_reset)
				begin
					state_d     = ST_PULSE;
					pulse_cnt_d = `WDTIT_RSTOUT_CYCLES;
				end
			end
			ST_PULSE:
			begin
				if (pulse_done)
					state_d = ST_IDLE;
				else
					pulse_cnt_d = pulse_cnt_q - 8'h01;
			end
			default:
			begin
				state_d     = ST_IDLE;
				pulse_cnt_d = 8'h00;
			end
		endcase
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q     <= ST_IDLE;
			pulse_cnt_q <= 8'h00;
		end
		else
		begin
			state_q     <= state_d;
			pulse_cnt_q <= pulse_cnt_d;
		end
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			internal_reset_req <= 1'b0;
			reset_out_pin_n    <= 1'b1;
			nmi_req            <= 1'b0;
		end
		else
		begin
			internal_reset_req <= (state_d == ST_PULSE);
			reset_out_pin_n    <= ~(state_d == ST_PULSE);
			nmi_req            <= wrap_nmi;
		end
	end

	// event status: sticky, cleared by a read, an event in the read cycle stays
	always @*
	begin
		evt_status_d = evt_status_q;
		if (reg_rd && hit_status)
			evt_status_d = `WDTIT_RST_EVT;
		if (wrap_interval)
			evt_status_d[`WDTIT_EVT_INTERVAL] = 1'b1;
		if (wr_bad)
			evt_status_d[`WDTIT_EVT_GUARD] = 1'b1;
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			evt_status_q <= `WDTIT_RST_EVT;
		else
			evt_status_q <= evt_status_d;
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			evt_mask_q <= `WDTIT_RST_EVT;
		else if (reg_wr && hit_mask)
			evt_mask_q <= reg_wdata[`WDTIT_EVT_W-1:0];
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			interval_irq <= 1'b0;
		else
			interval_irq <= |(evt_status_d & evt_mask_q);
	end

	// read data stands in the cycle after the strobe only
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else
		begin
			case (reg_addr)
				`WDTIT_OFS_COUNT:      reg_rdata <= count_q;
				`WDTIT_OFS_CTRL:       reg_rdata <= ctrl_view;
				`WDTIT_OFS_KEY:        reg_rdata <= {7'h00, unlock_q};
				`WDTIT_OFS_EVT_STATUS: reg_rdata <= {6'h00, evt_status_q};
				`WDTIT_OFS_EVT_MASK:   reg_rdata <= {6'h00, evt_mask_q};
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule
